// ==== ext_data_access.sv ====
// Purpose: data pointers, stretch control and external data transfer pins
// Assumes: CPU issues one request at a time and waits for cpu_ready
// Notes: pins lag the sequencer by one clock; read data is synchronised
`timescale 1ns/1ps
`include "stretch_consts.svh"
module ext_data_access (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // SFR port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // CPU pointer and transfer requests
    input wire stretch_pkg::cpu_req_s cpu_req,
    output logic cpu_ready,
    output logic cpu_done,
    output logic [7:0] cpu_rdata,
    // Memory pins
    output logic [7:0] low_address_data_port_out,
    output logic low_address_data_port_oe,
    input wire logic [7:0] low_address_data_port_in,
    output logic [7:0] high_address_port,
    output logic ale,
    output logic rd_n,
    output logic wr_n
);
    logic [15:0] ptr_reg [0:1];
    logic select_reg;
    logic [7:0] clk_ctrl_reg;
    logic [1:0] phase_reg;
    logic pend_reg;
    logic write_reg;
    logic [15:0] xfer_addr_reg;
    logic [7:0] xfer_wdata_reg;
    logic [7:0] sync1_reg;
    logic [7:0] sync2_reg;
    logic start;
    logic accept;
    logic seq_busy;
    logic [2:0] xfer_stretch;
    stretch_pkg::flags_s flags;

    assign accept = cpu_ready && (cpu_req.op == stretch_pkg::OP_READ || cpu_req.op == stretch_pkg::OP_WRITE);
    assign start = pend_reg && phase_reg == `MC_LAST_PHASE;

    // Free machine-cycle phase; it runs on through stretched transfers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_reg <= 2'h0;
        end else begin
            phase_reg <= phase_reg + 2'h1;
        end
    end

    // Clock control; upper bits are kept for other units
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_ctrl_reg <= `CLK_CTRL_RESET;
        end else if (sfr_wr && sfr_addr == `SFR_CLK_CTRL) begin
            clk_ctrl_reg <= sfr_wdata;
        end
    end

    // Pointer select; an SFR write keeps only bit 0 of the data
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            select_reg <= `SELECT_RESET;
        end else if (sfr_wr && sfr_addr == `SFR_SELECT) begin
            select_reg <= sfr_wdata[0];
        end
    end

    // Data pointers; an SFR byte write lands after a same-cycle CPU op
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ptr_reg[0] <= `PTR_RESET;
            ptr_reg[1] <= `PTR_RESET;
        end else begin
            if (cpu_ready && cpu_req.op == stretch_pkg::OP_LOAD) begin
                ptr_reg[select_reg] <= cpu_req.value;
            end else if (cpu_ready && cpu_req.op == stretch_pkg::OP_INC) begin
                ptr_reg[select_reg] <= ptr_reg[select_reg] + 16'h0001;
            end
            if (sfr_wr) begin
                case (sfr_addr)
                    `SFR_PTR0_LO: ptr_reg[0][7:0] <= sfr_wdata;
                    `SFR_PTR0_HI: ptr_reg[0][15:8] <= sfr_wdata;
                    `SFR_PTR1_LO: ptr_reg[1][7:0] <= sfr_wdata;
                    `SFR_PTR1_HI: ptr_reg[1][15:8] <= sfr_wdata;
                    default: ;
                endcase
            end
        end
    end

    // SFR read data, one clock after the strobe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sfr_rdata <= 8'h00;
            sfr_hit <= 1'b0;
        end else begin
            sfr_hit <= 1'b0;
            sfr_rdata <= 8'h00;
            if (sfr_rd) begin
                sfr_hit <= 1'b1;
                case (sfr_addr)
                    `SFR_PTR0_LO: sfr_rdata <= ptr_reg[0][7:0];
                    `SFR_PTR0_HI: sfr_rdata <= ptr_reg[0][15:8];
                    `SFR_PTR1_LO: sfr_rdata <= ptr_reg[1][7:0];
                    `SFR_PTR1_HI: sfr_rdata <= ptr_reg[1][15:8];
                    `SFR_SELECT: sfr_rdata <= {7'h00, select_reg};
                    `SFR_CLK_CTRL: sfr_rdata <= clk_ctrl_reg;
                    default: sfr_hit <= 1'b0;
                endcase
            end
        end
    end

    // Transfer request capture; start waits for a machine-cycle edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pend_reg <= 1'b0;
            write_reg <= 1'b0;
            xfer_addr_reg <= 16'h0000;
            xfer_wdata_reg <= 8'h00;
        end else if (accept) begin
            pend_reg <= 1'b1;
            write_reg <= (cpu_req.op == stretch_pkg::OP_WRITE);
            xfer_addr_reg <= ptr_reg[select_reg];
            xfer_wdata_reg <= cpu_req.wdata;
        end else if (start) begin
            pend_reg <= 1'b0;
        end
    end

    // Ready drops on a transfer and returns with done
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_ready <= 1'b1;
            cpu_done <= 1'b0;
        end else begin
            cpu_done <= flags.last;
            if (accept) begin
                cpu_ready <= 1'b0;
            end else if (flags.last) begin
                cpu_ready <= 1'b1;
            end
        end
    end

    stretch_sequencer u_seq (
        .clk(clk),
        .arst_n(arst_n),
        .start(start),
        .stretch(clk_ctrl_reg[`STRETCH_MSB:`STRETCH_LSB]),
        .busy(seq_busy),
        .xfer_stretch(xfer_stretch),
        .flags(flags)
    );

    // Pin drive; port is released for reads after the address phase
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ale <= 1'b0;
            low_address_data_port_oe <= 1'b0;
            low_address_data_port_out <= 8'h00;
            high_address_port <= 8'h00;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
        end else begin
            ale <= flags.ale;
            low_address_data_port_oe <= flags.addr || (flags.wdata && write_reg && seq_busy);
            low_address_data_port_out <= flags.addr ? xfer_addr_reg[7:0] : xfer_wdata_reg;
            high_address_port <= xfer_addr_reg[15:8];
            rd_n <= !(flags.strobe && !write_reg);
            wr_n <= !(flags.strobe && write_reg);
        end
    end

    // Read data passes two flops; capture point allows for that lag
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_reg <= 8'h00;
            sync2_reg <= 8'h00;
            cpu_rdata <= 8'h00;
        end else begin
            sync1_reg <= low_address_data_port_in;
            sync2_reg <= sync1_reg;
            if (flags.capture && !write_reg) begin
                cpu_rdata <= sync2_reg;
            end
        end
    end

    // Helpers for the checks below
    logic [5:0] strobe_cnt;
    logic [5:0] xfer_cnt;
    logic first_cycle;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            strobe_cnt <= 6'h00;
            xfer_cnt <= 6'h00;
            first_cycle <= 1'b1;
        end else begin
            strobe_cnt <= (!rd_n || !wr_n) ? strobe_cnt + 6'h01 : 6'h00;
            xfer_cnt <= start ? 6'h00 : xfer_cnt + 6'h01;
            first_cycle <= 1'b0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    stretch_reset_a: assert property (first_cycle |-> clk_ctrl_reg == `CLK_CTRL_RESET && select_reg == `SELECT_RESET)
        else $error("stretch or select wrong after reset");
    select_upper_zero_a: assert property (sfr_rd && sfr_addr == `SFR_SELECT |=> sfr_hit && sfr_rdata[7:1] == 7'h00)
        else $error("select upper bits not zero");
    strobe_width_a: assert property ($rose(rd_n) || $rose(wr_n) |-> strobe_cnt == stretch_pkg::strobe_width(xfer_stretch))
        else $error("strobe width wrong");
    xfer_length_a: assert property (cpu_done |-> xfer_cnt == stretch_pkg::xfer_clks(xfer_stretch))
        else $error("transfer length wrong");
    phase_align_a: assert property (start |-> phase_reg == `MC_LAST_PHASE ##1 seq_busy)
        else $error("transfer not machine-cycle aligned");
    latch_before_strobe_a: assert property ($fell(rd_n) || $fell(wr_n) |-> !ale && $past(ale, 3))
        else $error("address latch not ahead of strobe");
    addr_on_port_a: assert property (ale |-> low_address_data_port_oe && low_address_data_port_out == xfer_addr_reg[7:0])
        else $error("low address missing during latch");
    high_addr_held_a: assert property (!rd_n || !wr_n |-> high_address_port == xfer_addr_reg[15:8] && $stable(xfer_stretch))
        else $error("high address or stretch moved during strobe");
    read_released_a: assert property (!rd_n |-> !low_address_data_port_oe)
        else $error("port driven during read strobe");
    inc_routes_a: assert property (cpu_ready && cpu_req.op == stretch_pkg::OP_INC && !sfr_wr |=> ptr_reg[$past(select_reg)] == $past(ptr_reg[select_reg]) + 16'h0001)
        else $error("increment missed selected pointer");

    fast_read_c: cover property (cpu_done && !write_reg && xfer_stretch == 3'h0);
    slow_write_c: cover property (cpu_done && write_reg && xfer_stretch == 3'h7);
    pointer_switch_c: cover property (sfr_wr && sfr_addr == `SFR_SELECT && sfr_wdata[0] != select_reg);
    pointer_inc_c: cover property (cpu_ready && cpu_req.op == stretch_pkg::OP_INC && select_reg);
endmodule : ext_data_access

// ==== stretch_consts.svh ====
// Purpose: named constants for the stretched external data access block
// Assumes: included by bare name, after stretch_pkg where types are needed
// Notes: offsets are special-function addresses on the internal SFR port
`ifndef STRETCH_CONSTS_SVH
`define STRETCH_CONSTS_SVH
`define SFR_PTR0_LO 8'h82
`define SFR_PTR0_HI 8'h83
`define SFR_PTR1_LO 8'h84
`define SFR_PTR1_HI 8'h85
`define SFR_SELECT 8'h86
`define SFR_CLK_CTRL 8'h8E
`define CLK_CTRL_RESET 8'h01
`define SELECT_RESET 1'h0
`define PTR_RESET 16'h0000
`define STRETCH_MSB 2
`define STRETCH_LSB 0
`define MC_LAST_PHASE 2'h3
`define CLKS_PER_MC 6'h04
`define MIN_MCS 6'h02
`define STROBE_W_ZERO 6'h02
`define ALE_LAST 6'h01
`define ADDR_LAST 6'h02
`define WDATA_FIRST 6'h03
`define STROBE_FIRST 6'h04
`define CAPTURE_LAG 6'h02
`endif

// ==== stretch_pkg.sv ====
// Purpose: shared types and timing functions for the external data access block
// Assumes: stretch_consts.svh holds every number
// Notes: functions give transfer length and strobe width in clocks
`include "stretch_consts.svh"
package stretch_pkg;
    typedef enum logic [2:0] {OP_NONE, OP_LOAD, OP_INC, OP_READ, OP_WRITE} op_e;
    typedef enum logic {SEQ_IDLE, SEQ_RUN} seq_state_e;
    typedef struct packed {
        op_e op;
        logic [15:0] value;
        logic [7:0] wdata;
    } cpu_req_s;
    typedef struct packed {
        logic ale;
        logic addr;
        logic wdata;
        logic strobe;
        logic capture;
        logic last;
    } flags_s;
    // Clocks in one external data transfer
    function automatic logic [5:0] xfer_clks(input logic [2:0] s);
        xfer_clks = 6'(({3'h0, s} + `MIN_MCS) * `CLKS_PER_MC);
    endfunction : xfer_clks
    // Read or write strobe width in clocks
    function automatic logic [5:0] strobe_width(input logic [2:0] s);
        strobe_width = (s == 3'h0) ? `STROBE_W_ZERO : 6'({3'h0, s} * `CLKS_PER_MC);
    endfunction : strobe_width
endpackage : stretch_pkg

// ==== stretch_sequencer.sv ====
// Purpose: clock-by-clock timing of one stretched external data transfer
// Assumes: start arrives in the last clock of a machine cycle
// Notes: flags are registered and line up with the count they decode
`timescale 1ns/1ps
`include "stretch_consts.svh"
module stretch_sequencer (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Control
    input wire logic start,
    input wire logic [2:0] stretch,
    // Status
    output logic busy,
    output logic [2:0] xfer_stretch,
    output stretch_pkg::flags_s flags
);
    stretch_pkg::seq_state_e state_reg;
    logic [5:0] cnt_reg;

    // Decode of one clock position in the transfer
    function automatic stretch_pkg::flags_s decode(input logic [5:0] c, input logic [2:0] s);
        logic [5:0] cap;
        decode = '0;
        cap = `STROBE_FIRST + stretch_pkg::strobe_width(s) + `CAPTURE_LAG;
        if (cap > stretch_pkg::xfer_clks(s) - 6'h01) begin
            cap = stretch_pkg::xfer_clks(s) - 6'h01;
        end
        decode.ale = (c <= `ALE_LAST);
        decode.addr = (c <= `ADDR_LAST);
        decode.wdata = (c >= `WDATA_FIRST);
        decode.strobe = (c >= `STROBE_FIRST) && (c < `STROBE_FIRST + stretch_pkg::strobe_width(s));
        decode.capture = (c == cap);
        decode.last = (c == stretch_pkg::xfer_clks(s) - 6'h01);
    endfunction : decode

    // Stretch is sampled once so a rewrite mid-transfer waits for the next one
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            xfer_stretch <= 3'h0;
        end else if (start && state_reg == stretch_pkg::SEQ_IDLE) begin
            xfer_stretch <= stretch;
        end
    end

    // Position counter and flags
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= stretch_pkg::SEQ_IDLE;
            cnt_reg <= 6'h00;
            flags <= '0;
            busy <= 1'b0;
        end else begin
            case (state_reg)
                stretch_pkg::SEQ_IDLE: begin
                    flags <= '0;
                    if (start) begin
                        state_reg <= stretch_pkg::SEQ_RUN;
                        cnt_reg <= 6'h00;
                        flags <= decode(6'h00, stretch);
                        busy <= 1'b1;
                    end
                end
                stretch_pkg::SEQ_RUN: begin
                    if (flags.last) begin
                        state_reg <= stretch_pkg::SEQ_IDLE;
                        flags <= '0;
                        busy <= 1'b0;
                    end else begin
                        cnt_reg <= cnt_reg + 6'h01;
                        flags <= decode(cnt_reg + 6'h01, xfer_stretch);
                    end
                end
                default: begin
                    state_reg <= stretch_pkg::SEQ_IDLE;
                    busy <= 1'b0;
                end
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // Transfer covers whole machine cycles
    seq_length_a: assert property (flags.last |-> (cnt_reg + 6'h01) % `CLKS_PER_MC == 6'h00)
        else $error("transfer not a whole number of machine cycles");
    // Address latch pulse never overlaps the strobe
    ale_strobe_apart_a: assert property (!(flags.ale && flags.strobe))
        else $error("address latch overlaps strobe");
endmodule : stretch_sequencer

// ==== mem_model.sv ====
// Purpose: external byte-wide memory on the multiplexed transfer pins
// Assumes: low address byte is on the port while ale is high
// Notes: a released port shows the inverse of the last byte the model drove on a read, so stale data never looks valid
`timescale 1ns/1ps
module mem_model (
    // Clock
    input wire logic clk,
    // Memory pins
    input wire logic [7:0] port,
    input wire logic [7:0] high_addr,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    output logic [7:0] drive
);
    logic [7:0] mem [0:65535];
    logic [7:0] lo_reg;
    logic [7:0] last_reg = 8'h00;
    // Latch address, store writes, remember last driven byte
    always @(posedge clk) begin
        if (ale) lo_reg <= port;
        if (!wr_n) mem[{high_addr, lo_reg}] <= port;
        if (!rd_n) last_reg <= drive;
    end
    // Prompt answer while the read strobe is low
    assign drive = !rd_n ? mem[{high_addr, lo_reg}] : ~last_reg;
endmodule : mem_model

// ==== tb_top.sv ====
// Purpose: self-checking bench for the stretched external data access block
// Assumes: every task but final_report from the hang guard is entered 2 ns after a rising edge
// Notes: transfer length is checked as a window, since start waits for phase 3
`timescale 1ns/1ps
module tb_top;
    logic clk, arst_n, sfr_wr, sfr_rd, sfr_hit, cpu_ready, cpu_done, port_oe, ale, rd_n, wr_n;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, cpu_rdata, port_out, port_in, high_port, mem_drive;
    stretch_pkg::cpu_req_s cpu_req;
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    // Port level: the device wins while it drives
    assign port_in = port_oe ? port_out : mem_drive;
    ext_data_access uut (.clk(clk), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .cpu_req(cpu_req),
        .cpu_ready(cpu_ready), .cpu_done(cpu_done), .cpu_rdata(cpu_rdata),
        .low_address_data_port_out(port_out), .low_address_data_port_oe(port_oe),
        .low_address_data_port_in(port_in), .high_address_port(high_port), .ale(ale), .rd_n(rd_n), .wr_n(wr_n));
    mem_model mem (.clk(clk), .port(port_in), .high_addr(high_port), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
        .drive(mem_drive));
    // Clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report
    // Hang guard, far above the expected run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            final_report();
        end
    end
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            n_errors++;
        end
    endtask : check
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge clk);
        #2;
        sfr_wr = 1'b0;
        // Idle edge so a following call never reassigns a strobe in this time step
        @(posedge clk);
        #2;
    endtask : sfr_write
    task automatic sfr_expect(input logic [7:0] a, input logic [7:0] exp, input logic hit);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge clk);
        #2;
        sfr_rd = 1'b0;
        check("sfr data", {8'h00, exp}, {8'h00, sfr_rdata});
        check("sfr hit", {15'h0, hit}, {15'h0, sfr_hit});
        // Idle edge so back-to-back reads never reassign sfr_rd in one time step
        @(posedge clk);
        #2;
    endtask : sfr_expect
    task automatic cpu_op(input stretch_pkg::op_e op, input logic [15:0] v, input logic [7:0] wd);
        cpu_req = '{op: op, value: v, wdata: wd};
        @(posedge clk);
        #2;
        cpu_req.op = stretch_pkg::OP_NONE;
        // Idle edge so back-to-back requests never reassign op in one time step
        @(posedge clk);
        #2;
    endtask : cpu_op
    // One pointer load then one transfer, with pin timing judged clock by clock
    task automatic xfer(input stretch_pkg::op_e op, input logic [15:0] a, input logic [7:0] wd, input int s,
        input int rewrite);
        int n, strobe, other, ale_n, late, rdy;
        logic [7:0] lo;
        n = 0;
        strobe = 0;
        other = 0;
        ale_n = 0;
        late = 0;
        rdy = 0;
        lo = 8'h00;
        cpu_op(stretch_pkg::OP_LOAD, a, 8'h00);
        cpu_op(op, 16'h0000, wd);
        while (cpu_done !== 1'b1 && n < 300) begin
            sfr_wr = (n == 2 && rewrite >= 0);
            sfr_addr = 8'h8E;
            sfr_wdata = 8'(rewrite);
            @(posedge clk);
            #2;
            n++;
            if (cpu_ready === 1'b1) rdy++;
            if (ale === 1'b1 && port_oe === 1'b1) lo = port_out;
            if (ale === 1'b1) ale_n++;
            if ((op == stretch_pkg::OP_READ ? rd_n : wr_n) === 1'b0) strobe++;
            if ((op == stretch_pkg::OP_READ ? rd_n : wr_n) === 1'b0 && ale_n == 0) late = 1;
            if ((op == stretch_pkg::OP_READ ? wr_n : rd_n) === 1'b0) other++;
        end
        // Loop opens two clocks after accept; start then waits 0..3 clocks for phase 3
        check("length in window", 16'h1, 16'(n >= (s + 2) * 4 && n <= (s + 2) * 4 + 3));
        check("ready high clocks", 16'h1, 16'(rdy));
        check("strobe width", 16'((s == 0) ? 2 : 4 * s), 16'(strobe));
        check("other strobe", 16'h0, 16'(other));
        check("ale clocks", 16'h2, 16'(ale_n));
        check("ale before strobe", 16'h0, 16'(late));
        check("low address", {8'h00, a[7:0]}, {8'h00, lo});
        check("high address", {8'h00, a[15:8]}, {8'h00, high_port});
        if (op == stretch_pkg::OP_READ) check("read data", {8'h00, wd}, {8'h00, cpu_rdata});
    endtask : xfer
    // Reset values and an unmapped place
    task automatic test_reset();
        sfr_expect(8'h8E, 8'h01, 1'b1);
        sfr_expect(8'h86, 8'h00, 1'b1);
        sfr_expect(8'h87, 8'h00, 1'b0);
    endtask : test_reset
    // Select keeps bit 0 only
    task automatic test_select();
        sfr_write(8'h86, 8'hFF);
        sfr_expect(8'h86, 8'h01, 1'b1);
        sfr_write(8'h86, 8'h02);
        sfr_expect(8'h86, 8'h00, 1'b1);
    endtask : test_select
    // Loads and increment land in the selected pointer only
    task automatic test_pointers();
        cpu_op(stretch_pkg::OP_LOAD, 16'h1234, 8'h00);
        sfr_write(8'h86, 8'h01);
        cpu_op(stretch_pkg::OP_LOAD, 16'h12FF, 8'h00);
        cpu_op(stretch_pkg::OP_INC, 16'h0000, 8'h00);
        sfr_expect(8'h82, 8'h34, 1'b1);
        sfr_expect(8'h83, 8'h12, 1'b1);
        sfr_expect(8'h84, 8'h00, 1'b1);
        sfr_expect(8'h85, 8'h13, 1'b1);
        sfr_write(8'h84, 8'hA5);
        sfr_expect(8'h84, 8'hA5, 1'b1);
    endtask : test_pointers
    // Every stretch value, write then read back
    task automatic test_stretch();
        for (int s = 0; s < 8; s++) begin
            sfr_write(8'h8E, 8'(s));
            sfr_expect(8'h8E, 8'(s), 1'b1);
            xfer(stretch_pkg::OP_WRITE, {8'(8'h40 + s), 8'(8'h10 + s)}, 8'(8'hA0 + s), s, -1);
            xfer(stretch_pkg::OP_READ, {8'(8'h40 + s), 8'(8'h10 + s)}, 8'(8'hA0 + s), s, -1);
        end
    endtask : test_stretch
    // Stretch rewritten mid-transfer applies to the next one only
    task automatic test_rewrite();
        xfer(stretch_pkg::OP_READ, 16'h4717, 8'hA7, 7, 0);
        sfr_expect(8'h8E, 8'h00, 1'b1);
        xfer(stretch_pkg::OP_READ, 16'h4010, 8'hA0, 0, -1);
    endtask : test_rewrite
    // Main sequence
    initial begin
        arst_n = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        cpu_req = '{op: stretch_pkg::OP_NONE, value: 16'h0000, wdata: 8'h00};
        repeat (16) @(posedge clk);
        #2;
        arst_n = 1'b1;
        test_reset();
        test_select();
        test_pointers();
        test_stretch();
        test_rewrite();
        final_report();
    end
endmodule : tb_top
